// File: lcea_cfg.svh
// constants for the line-cycle energy accumulator: offsets, field positions, timing counts
// assumes: included by its bare name from the package and the design module
//
// What this block does
// - two-bit field selects signed or absolute power for the pulse frequency output
// - watt-hour accumulation is always signed, whatever the frequency output setting
// - line-cycle mode ties accumulation to voltage zero crossings, whole half-cycles
// - after programmed half-cycles, internal 32-bit sums move into watt-hour registers
// - line-cycle accumulation runs only while enable bit zero is set
// - three-bit field picks which phase zero crossings count, any combination
// - half-cycle target is a 16-bit unsigned count, up to 65,535 crossings
// - zero-crossing counter always runs, so first line-cycle result may be wrong
// - writing the count while line-cycle mode is on resets the crossing counter
// - end of each line-cycle interval sets the line-energy flag, status bit five
// - flag set with its mask bit on drives the active-low interrupt pin low
// - writing one to the flag position clears it and releases the pin
// - line-cycle mode uses the normal accumulation path and LSB weight
// - per-phase 24-bit instantaneous reactive power registers, full scale PMAX/16
// - fundamental reactive power settles within 375 ms (63%) and 875 ms (full)
// - clear-on-read outside line-cycle mode zeroes watt-hour registers after a read
// - outside line-cycle mode a watt-hour read copies the internal sums across; writes do not
`ifndef LCEA_CFG_SVH
`define LCEA_CFG_SVH

// register byte offsets
`define LCEA_OFS_ACC_CFG    8'h00
`define LCEA_OFS_LC_CFG     8'h04
`define LCEA_OFS_HALF_CYC   8'h08
`define LCEA_OFS_FLAGS      8'h0C
`define LCEA_OFS_IRQ_EN     8'h10
`define LCEA_OFS_VAR_A      8'h14
`define LCEA_OFS_ENERGY0    8'h20
`define LCEA_OFS_MISC       8'h38
`define LCEA_NUM_ENERGY     6

// field positions
`define LCEA_ACTIVE_FREQ_OUTPUT_MODE_LSB    0
`define LCEA_LC_EN_BIT      0
`define LCEA_ZERO_CROSS_PHASE_SELECT_LSB      3
`define LCEA_CLR_READ_BIT   6
`define LCEA_LINE_ENERGY_DONE_FLAG_BIT    5

// reset values
`define LCEA_RST_ACC_CFG    8'h00
`define LCEA_RST_LC_CFG     8'h38
`define LCEA_RST_HALF_CYC   16'h0000

// reactive full-scale figure
`define LCEA_PMAX           33516139
`define LCEA_VAR_FS         (`LCEA_PMAX / 16)

// settling times and clock
`define LCEA_SETTLE63_MS    375
`define LCEA_SETTLEFS_MS    875
`define LCEA_CLK_MHZ        250
`define LCEA_MS_TO_CYC(ms)  ((ms) * `LCEA_CLK_MHZ * 1000)

`endif

// File: lcea_pkg.sv
// types shared by the line-cycle energy accumulator
// assumes: lcea_cfg.svh is on the include path
`include "lcea_cfg.svh"

package lcea_pkg;

  // signed watt-hour word
  typedef logic signed [31:0] lcea_energy_t;

  // frequency output power format
  typedef enum logic [1:0] {
    LCEA_FREQ_SIGNED = 2'h0,
    LCEA_FREQ_ABS    = 2'h2
  } lcea_freq_mode_e;

  // bus answer state, one-hot
  typedef enum logic [1:0] {
    LCEA_BUS_IDLE = 2'b01,
    LCEA_BUS_ANS  = 2'b10
  } lcea_bus_e;

endpackage : lcea_pkg

// File: lcea_line_cycle.sv
// line-cycle active energy accumulation with APB register access
// assumes: one clock mclk, synchronous active-high reset, energy pulses and zero
// crossings arrive as one-cycle pulses synchronous to mclk from the DSP stage
// assumes: software keeps clear-on-read off while line-cycle mode is on
// unmapped addresses answer with pslverr and read as zero
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "lcea_cfg.svh"

module lcea_line_cycle
  import lcea_pkg::*;
#(
  parameter int unsigned SETTLE63_CYC = `LCEA_MS_TO_CYC(`LCEA_SETTLE63_MS),
  parameter int unsigned SETTLEFS_CYC = `LCEA_MS_TO_CYC(`LCEA_SETTLEFS_MS)
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // energy pulses: bits 2:0 total a/b/c, bits 5:3 fundamental a/b/c
  input  wire logic [5:0]  energyPulse,
  input  wire logic [5:0]  energyNeg,
  // voltage zero crossings a/b/c
  input  wire logic [2:0]  zeroCross,
  // instantaneous reactive power a/b/c
  input  wire logic [71:0] reactiveIn,
  input  wire logic [2:0]  reactiveValid,
  // pulse frequency output feed
  output logic [5:0]       freqPulse,
  output logic [5:0]       freqNeg,
  // interrupt
  output logic             interruptOutN
);

  // register state
  logic [7:0]         accCfg_q;
  logic [7:0]         lcCfg_q;
  logic [15:0]        halfCyc_q;
  logic               doneFlag_q;
  logic               doneMask_q;
  logic [23:0]        var_q [3];
  lcea_energy_t       acc_q [6];
  lcea_energy_t       acc_d [6];
  lcea_energy_t       accNext [6];
  lcea_energy_t       energy_q [6];
  lcea_energy_t       energy_d [6];
  logic [15:0]        zcCount_q;
  logic [15:0]        zcCount_d;
  logic [31:0]        settleCnt_q;
  logic               settled63_q;
  logic               settledFs_q;
  lcea_bus_e          bus_q;
  logic               pready_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  logic [5:0]         freqPulse_q;
  logic [5:0]         freqNeg_q;
  logic               irqN_q;

  // bus decode
  logic        accFirst;
  logic        wrDone;
  logic [31:0] rdMux;
  logic        mapped;
  logic        isEnergy;
  logic [2:0]  energyIdx;
  logic [7:0]  energyOfs;
  logic        wrAccCfg;
  logic        wrLcCfg;
  logic        wrHalfCyc;
  logic        wrFlagClr;
  logic        wrMask;

  assign accFirst  = psel && penable && (bus_q == LCEA_BUS_IDLE);
  assign wrDone    = psel && penable && pwrite && pready_q;
  assign energyOfs = paddr - `LCEA_OFS_ENERGY0;
  assign energyIdx = energyOfs[4:2];
  assign isEnergy  = (paddr >= `LCEA_OFS_ENERGY0) && (paddr < `LCEA_OFS_MISC) && (paddr[1:0] == 2'h0);
  assign wrAccCfg  = wrDone && (paddr == `LCEA_OFS_ACC_CFG) && pstrb[0];
  assign wrLcCfg   = wrDone && (paddr == `LCEA_OFS_LC_CFG) && pstrb[0];
  assign wrHalfCyc = wrDone && (paddr == `LCEA_OFS_HALF_CYC) && (pstrb[1:0] != 2'h0);
  assign wrMask    = wrDone && (paddr == `LCEA_OFS_IRQ_EN) && pstrb[0];
  assign wrFlagClr = wrDone && (paddr == `LCEA_OFS_FLAGS) && pstrb[0] && pwdata[`LCEA_LINE_ENERGY_DONE_FLAG_BIT];

  // control fields
  logic        lcEn;
  logic        clrOnRead;
  logic [2:0]  zero_cross_phase_select;
  logic        absMode;

  assign lcEn      = lcCfg_q[`LCEA_LC_EN_BIT];
  assign clrOnRead = lcCfg_q[`LCEA_CLR_READ_BIT] && !lcEn;
  assign zero_cross_phase_select     = lcCfg_q[`LCEA_ZERO_CROSS_PHASE_SELECT_LSB +: 3];
  assign absMode   = (accCfg_q[`LCEA_ACTIVE_FREQ_OUTPUT_MODE_LSB +: 2] == LCEA_FREQ_ABS);

  // zero-crossing counting, each enabled phase adds one
  logic [2:0]  zcHits;
  logic [1:0]  zcInc;
  logic [16:0] zcSum;
  logic        zcHit;
  logic        lcEnd;
  logic        cntReset;

  assign zcHits   = zeroCross & zero_cross_phase_select;
  assign zcInc    = 2'({1'b0, zcHits[0]} + {1'b0, zcHits[1]} + {1'b0, zcHits[2]});
  assign zcSum    = {1'b0, zcCount_q} + {15'h0000, zcInc};
  assign zcHit    = (halfCyc_q != 16'h0000) && (zcSum >= {1'b0, halfCyc_q});
  assign lcEnd    = zcHit && lcEn;
  assign cntReset = wrHalfCyc && lcEn;
  assign zcCount_d = cntReset ? 16'h0000 : (zcHit ? 16'h0000 : zcSum[15:0]);

  // watt-hour access outside line-cycle mode
  logic rdCopy;
  logic rdClear;

  assign rdCopy  = accFirst && !pwrite && isEnergy && !lcEn;
  assign rdClear = rdCopy && clrOnRead;

  // per-register signed accumulation, same path in both modes
  generate
    for (genvar g = 0; g < `LCEA_NUM_ENERGY; g++) begin : gAcc
      lcea_energy_t delta;
      assign delta = !energyPulse[g] ? 32'sh0 : (energyNeg[g] ? -32'sh1 : 32'sh1);
      assign accNext[g] = acc_q[g] + delta;
      assign acc_d[g] = (lcEnd || cntReset) ? 32'sh0 : (rdClear ? delta : accNext[g]);
      assign energy_d[g] = lcEnd ? accNext[g] :
                           rdClear ? 32'sh0 :
                           rdCopy ? acc_q[g] : energy_q[g];

      // accumulator and watt-hour register
      always_ff @(posedge mclk) begin
        if (srst) begin
          acc_q[g]    <= 32'sh0;
          energy_q[g] <= 32'sh0;
        end else begin
          acc_q[g]    <= acc_d[g];
          energy_q[g] <= energy_d[g];
        end
      end
    end
    for (genvar p = 0; p < 3; p++) begin : gVar
      // instantaneous reactive power capture
      always_ff @(posedge mclk) begin
        if (srst) begin
          var_q[p] <= 24'h000000;
        end else if (reactiveValid[p]) begin
          var_q[p] <= reactiveIn[24*p +: 24];
        end
      end
    end
  endgenerate

  // read data selection
  always_comb begin
    rdMux  = 32'h0000_0000;
    mapped = 1'b1;
    if (isEnergy) begin
      rdMux = lcEn ? energy_q[energyIdx] : acc_q[energyIdx];
    end else begin
      unique case (paddr)
        `LCEA_OFS_ACC_CFG:  rdMux = {24'h000000, accCfg_q};
        `LCEA_OFS_LC_CFG:   rdMux = {24'h000000, lcCfg_q};
        `LCEA_OFS_HALF_CYC: rdMux = {16'h0000, halfCyc_q};
        `LCEA_OFS_FLAGS:    rdMux = {26'h0, doneFlag_q, 5'h00};
        `LCEA_OFS_IRQ_EN:   rdMux = {26'h0, doneMask_q, 5'h00};
        8'h14:              rdMux = {8'h00, var_q[0]};
        8'h18:              rdMux = {8'h00, var_q[1]};
        8'h1C:              rdMux = {8'h00, var_q[2]};
        `LCEA_OFS_MISC:     rdMux = {zcCount_q, 14'h0000, settledFs_q, settled63_q};
        default:            mapped = 1'b0;
      endcase
    end
  end

  // apb answer: one wait state, data and error registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_q     <= LCEA_BUS_IDLE;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (accFirst) begin
      bus_q     <= LCEA_BUS_ANS;
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr_q <= !mapped;
    end else begin
      bus_q     <= LCEA_BUS_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // software-written configuration
  always_ff @(posedge mclk) begin
    if (srst) begin
      accCfg_q   <= `LCEA_RST_ACC_CFG;
      lcCfg_q    <= `LCEA_RST_LC_CFG;
      halfCyc_q  <= `LCEA_RST_HALF_CYC;
      doneMask_q <= 1'b0;
    end else begin
      if (wrAccCfg) accCfg_q <= pwdata[7:0];
      if (wrLcCfg) lcCfg_q <= pwdata[7:0];
      if (wrHalfCyc) halfCyc_q <= pwdata[15:0];
      if (wrMask) doneMask_q <= pwdata[`LCEA_LINE_ENERGY_DONE_FLAG_BIT];
    end
  end

  // crossing counter, line-energy flag and interrupt pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      zcCount_q  <= 16'h0000;
      doneFlag_q <= 1'b0;
      irqN_q     <= 1'b1;
    end else begin
      zcCount_q  <= zcCount_d;
      doneFlag_q <= lcEnd || (doneFlag_q && !wrFlagClr);
      irqN_q     <= !((lcEnd || (doneFlag_q && !wrFlagClr)) && doneMask_q);
    end
  end

  // frequency output feed: sign dropped in absolute mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      freqPulse_q <= 6'h00;
      freqNeg_q   <= 6'h00;
    end else begin
      freqPulse_q <= energyPulse;
      freqNeg_q   <= energyPulse & energyNeg & {6{!absMode}};
    end
  end

  // fundamental reactive settling indicators from reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      settleCnt_q <= 32'h0000_0000;
      settled63_q <= 1'b0;
      settledFs_q <= 1'b0;
    end else begin
      if (!settledFs_q) settleCnt_q <= settleCnt_q + 32'h0000_0001;
      settled63_q <= settled63_q || (settleCnt_q >= 32'(SETTLE63_CYC));
      settledFs_q <= settledFs_q || (settleCnt_q >= 32'(SETTLEFS_CYC));
    end
  end

  // outputs straight from flops
  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign freqPulse     = freqPulse_q;
  assign freqNeg       = freqNeg_q;
  assign interruptOutN = irqN_q;

  // accumulator advances by its own pulse only
  logic accPlain;
  assign accPlain = !(lcEnd || cntReset || rdClear);

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // pin low one cycle after a masked-in flag
  chk_irq_follows: assert property (doneFlag_q && doneMask_q && !wrFlagClr |=> !interruptOutN)
    else $error("interrupt pin not low with flag and mask set");

  // pin stays high while the flag is masked out
  chk_irq_masked: assert property (!doneMask_q |=> interruptOutN)
    else $error("interrupt pin low with mask clear");

  // interval end raises the line-energy flag
  chk_flag_sets: assert property (lcEnd |=> doneFlag_q)
    else $error("line-energy flag missed at interval end");

  // write-one-to-clear drops flag and pin together
  chk_flag_clear: assert property (wrFlagClr && !lcEnd |=> !doneFlag_q && interruptOutN)
    else $error("flag or pin not released by write-one-to-clear");

  // total sum moves across and restarts at the interval end
  chk_lc_transfer: assert property (lcEnd |=> energy_q[0] == $past(accNext[0]) && acc_q[0] == 32'sh0)
    else $error("line-cycle transfer wrong");

  // fundamental sum moves across the same way
  chk_fund_transfer: assert property (lcEnd |=> energy_q[3] == $past(accNext[3]) && acc_q[3] == 32'sh0)
    else $error("fundamental line-cycle transfer wrong");

  // an interval ends only on an enabled crossing
  chk_end_on_cross: assert property (lcEnd |-> (zeroCross & zero_cross_phase_select) != 3'h0)
    else $error("interval ended without an enabled crossing");

  // no flag rise with line-cycle mode off
  chk_lc_gated: assert property (!lcEn |=> $stable(doneFlag_q) || !doneFlag_q)
    else $error("flag set while line-cycle mode off");

  // watt-hour words hold outside line-cycle mode unless accessed
  chk_mode_off_hold: assert property (!lcEn && !rdCopy |=> energy_q[0] == $past(energy_q[0]))
    else $error("watt-hour word moved with line-cycle mode off");

  // count write in line-cycle mode zeroes the crossing counter
  chk_count_reset: assert property (cntReset |=> zcCount_q == 16'h0000)
    else $error("crossing counter not reset by count write");

  // count write in line-cycle mode also restarts the sums
  chk_count_write_acc: assert property (cntReset |=> acc_q[4] == 32'sh0)
    else $error("accumulator not cleared by count write");

  // counter restarts at the target
  chk_count_restart: assert property (zcHit |=> zcCount_q == 16'h0000)
    else $error("half-cycle count not restarted");

  // counter runs in either mode, adding every enabled crossing
  chk_count_runs: assert property (zcInc != 2'h0 && !zcHit && !cntReset |=>
    zcCount_q == $past(zcCount_q) + 16'($past(zcInc)))
    else $error("crossing counter did not advance");

  // three simultaneous crossings count three
  chk_all_phases: assert property (zeroCross == 3'b111 && zero_cross_phase_select == 3'b111 |-> zcInc == 2'h3)
    else $error("simultaneous crossings not counted separately");

  // a lone positive pulse steps the sum by one
  chk_pos_step: assert property (energyPulse[0] && !energyNeg[0] && accPlain |=>
    acc_q[0] == $past(acc_q[0]) + 32'sh1)
    else $error("positive pulse did not add one");

  // sums stay signed in absolute frequency mode
  chk_abs_signed: assert property (absMode && energyPulse[0] && energyNeg[0] && accPlain |=>
    acc_q[0] == $past(acc_q[0]) - 32'sh1)
    else $error("negative pulse not subtracted");

  // reactive word captured on its strobe
  chk_var_capture: assert property (reactiveValid[1] |=> var_q[1] == $past(reactiveIn[47:24]))
    else $error("reactive power not captured");

  // captured reactive word holds between strobes
  chk_var_hold: assert property (!reactiveValid[0] |=> $stable(var_q[0]))
    else $error("reactive word changed without a strobe");

  // frequency feed copies the pulses one cycle later
  chk_freq_copy: assert property (energyPulse != 6'h00 |=> freqPulse == $past(energyPulse))
    else $error("frequency feed lost a pulse");

  // signed mode passes the sign through
  chk_freq_signed: assert property (!absMode && energyPulse[0] && energyNeg[0] |=> freqNeg[0])
    else $error("signed mode dropped a sign");

  // absolute mode drops the sign
  chk_abs_mode: assert property (absMode && energyPulse[0] |=> freqPulse[0] && !freqNeg[0])
    else $error("absolute mode kept a sign");

  // partial settling flag rises no later than its count
  chk_settle_partial: assert property (!settled63_q |-> settleCnt_q <= 32'(SETTLE63_CYC))
    else $error("partial settling flag late");

  // full settling flag rises no later than its count
  chk_settle_full: assert property (!settledFs_q |-> settleCnt_q <= 32'(SETTLEFS_CYC))
    else $error("full settling flag late");

  // read outside line-cycle mode copies the sum
  chk_read_copy: assert property (rdCopy && !rdClear |=> energy_q[3] == $past(acc_q[3]))
    else $error("access did not copy accumulator");

  // clear-on-read zeroes the watt-hour words
  chk_read_clear: assert property (rdClear |=> energy_q[2] == 32'sh0)
    else $error("clear-on-read left a watt-hour word");

  // reads in line-cycle mode leave the words alone
  chk_lc_read_keep: assert property (lcEn && !lcEnd && accFirst && !pwrite && isEnergy |=>
    $stable(energy_q[1]))
    else $error("line-cycle read changed a watt-hour word");

  // main scenarios reached
  cov_lc_end: cover property (lcEnd ##[1:20] wrFlagClr);
  cov_read_clear: cover property (rdClear);
  cov_multi_cross: cover property (zcInc == 2'h3);
  cov_abs_pulse: cover property (absMode && energyPulse[0]);
  cov_count_write: cover property (cntReset);

endmodule : lcea_line_cycle

// File: line_cycle_energy_accumulator_bench.sv
// self-checking bench for the line-cycle energy accumulator: apb registers, frequency feed, line-cycle intervals
// assumes: lcea_pkg and lcea_line_cycle compiled first, lcea_cfg.svh on the include path
`timescale 1ns/10ps
`include "lcea_cfg.svh"

module line_cycle_energy_accumulator_bench
  import lcea_pkg::*;
;
  logic        mclk          = 1'b0;
  logic        srst          = 1'b1;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [7:0]  paddr         = 8'h00;
  logic [31:0] pwdata        = 32'h0;
  logic [3:0]  pstrb         = 4'hF;
  logic [5:0]  energyPulse   = 6'h00;
  logic [5:0]  energyNeg     = 6'h00;
  logic [2:0]  zeroCross     = 3'h0;
  logic [71:0] reactiveIn    = 72'h0;
  logic [2:0]  reactiveValid = 3'h0;
  logic        pready, pslverr, interruptOutN, err;
  logic [31:0] prdata, rd;
  logic [5:0]  freqPulse, freqNeg;
  int          bad_count     = 0;
  int          cmp_count     = 0;
  int          cycles        = 0;

  // 250 MHz clock
  always #2 mclk = ~mclk;

  // device under test, settle counts shortened
  lcea_line_cycle #(.SETTLE63_CYC(20), .SETTLEFS_CYC(40)) i_lcea_line_cycle (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .energyPulse(energyPulse), .energyNeg(energyNeg), .zeroCross(zeroCross), .reactiveIn(reactiveIn),
    .reactiveValid(reactiveValid), .freqPulse(freqPulse), .freqNeg(freqNeg), .interruptOutN(interruptOutN));

  // verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // compare one value and count it
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read a register and compare
  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd, exp);
    check({31'h0, err}, 32'h0);
  endtask : rdchk

  // present one cycle of pulses and crossings
  task automatic drive(input logic [5:0] ep, input logic [5:0] en, input logic [2:0] zc);
    @(posedge mclk);
    energyPulse <= ep;
    energyNeg   <= en;
    zeroCross   <= zc;
  endtask : drive

  // reset values, full 16-bit count, unmapped address, early settle flags
  task automatic test_reset_values;
    rdchk(`LCEA_OFS_MISC, 32'h0);
    rdchk(`LCEA_OFS_ACC_CFG, 32'h00);
    rdchk(`LCEA_OFS_LC_CFG, 32'h38);
    rdchk(`LCEA_OFS_IRQ_EN, 32'h0);
    apb(1'b1, `LCEA_OFS_HALF_CYC, 32'h0000FFFF);
    rdchk(`LCEA_OFS_HALF_CYC, 32'h0000FFFF);
    apb(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : test_reset_values

  // every frequency mode with a negative total-A pulse; energy stays signed
  task automatic test_freq_modes;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `LCEA_OFS_ACC_CFG, 32'(m));
      drive(6'h01, 6'h01, 3'h0);
      drive(6'h00, 6'h00, 3'h0);
      #1;
      check({26'h0, freqPulse}, 32'h01);
      check({26'h0, freqNeg}, (2'(m) == LCEA_FREQ_ABS) ? 32'h0 : 32'h1);
    end
    rdchk(`LCEA_OFS_ENERGY0, 32'hFFFFFFFC);
  endtask : test_freq_modes

  // phase A interval of three crossings, phase B ignored, flag and pin
  task automatic test_line_cycle;
    apb(1'b1, `LCEA_OFS_LC_CFG, 32'h09);
    apb(1'b1, `LCEA_OFS_IRQ_EN, 32'h20);
    apb(1'b1, `LCEA_OFS_HALF_CYC, 32'h3);
    drive(6'h09, 6'h08, 3'b010);
    drive(6'h00, 6'h00, 3'b001);
    drive(6'h09, 6'h08, 3'b000);
    drive(6'h00, 6'h00, 3'b001);
    #1;
    check({31'h0, interruptOutN}, 32'h1);
    drive(6'h09, 6'h08, 3'b001);
    drive(6'h00, 6'h00, 3'b000);
    #1;
    check({31'h0, interruptOutN}, 32'h0);
    rdchk(`LCEA_OFS_FLAGS, 32'h20);
    rdchk(`LCEA_OFS_ENERGY0, 32'h3);
    rdchk(`LCEA_OFS_ENERGY0 + 8'h0C, 32'hFFFFFFFD);
    apb(1'b1, `LCEA_OFS_FLAGS, 32'h20);
    @(posedge mclk);
    #1;
    check({31'h0, interruptOutN}, 32'h1);
    rdchk(`LCEA_OFS_FLAGS, 32'h0);
  endtask : test_line_cycle

  // all phases enabled: one simultaneous crossing ends an interval of three
  task automatic test_phase_combine;
    apb(1'b1, `LCEA_OFS_LC_CFG, 32'h39);
    drive(6'h01, 6'h00, 3'b111);
    drive(6'h00, 6'h00, 3'b000);
    #1;
    check({31'h0, interruptOutN}, 32'h0);
    rdchk(`LCEA_OFS_ENERGY0, 32'h1);
    apb(1'b1, `LCEA_OFS_FLAGS, 32'h20);
  endtask : test_phase_combine

  // mode off with clear-on-read: a read returns live sum then zeroes it
  task automatic test_clear_on_read;
    apb(1'b1, `LCEA_OFS_LC_CFG, 32'h40);
    drive(6'h01, 6'h00, 3'b000);
    drive(6'h00, 6'h00, 3'b000);
    rdchk(`LCEA_OFS_ENERGY0, 32'h1);
    rdchk(`LCEA_OFS_ENERGY0, 32'h0);
  endtask : test_clear_on_read

  // reactive capture holds after the strobe, upper bits zero
  task automatic test_reactive;
    @(posedge mclk);
    reactiveIn    <= {24'h000123, 24'hE00960, 24'(`LCEA_VAR_FS)};
    reactiveValid <= 3'b111;
    @(posedge mclk);
    reactiveValid <= 3'b000;
    reactiveIn    <= 72'h0;
    rdchk(`LCEA_OFS_VAR_A, 32'(`LCEA_VAR_FS));
    rdchk(`LCEA_OFS_VAR_A + 8'h04, 32'h00E00960);
    rdchk(`LCEA_OFS_VAR_A + 8'h08, 32'h00000123);
    apb(1'b0, `LCEA_OFS_MISC, 32'h0);
    check({30'h0, rd[1:0]}, 32'h3);
  endtask : test_reactive

  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    test_reset_values();
    test_freq_modes();
    test_line_cycle();
    test_phase_combine();
    test_clear_on_read();
    test_reactive();
    summarize();
  end

endmodule : line_cycle_energy_accumulator_bench
